//--- src/nvm_pkg.sv
// Shared constants and types of the data storage access controller
package nvm_pkg;

  // ***********************************************************
  // Register offsets in data sector 1
  // ***********************************************************
  localparam logic [7:0] NVM_CTRL_OFS    = 8'h40;
  localparam logic [7:0] NVM_ADDR_LO_OFS = 8'h41;
  localparam logic [7:0] NVM_ADDR_HI_OFS = 8'h42;
  localparam logic [7:0] NVM_DATA_OFS    = 8'h43;
  localparam logic [7:0] NVM_REG_RESET   = 8'h00;

  // ***********************************************************
  // Control register fields
  // ***********************************************************
  localparam int NVM_CT_TSEL    = 7;
  localparam int NVM_CT_WIPE_EN = 6;
  localparam int NVM_CT_WIPE_GO = 5;
  localparam int NVM_CT_PAGE    = 4;
  localparam int NVM_CT_STOR_EN = 3;
  localparam int NVM_CT_STOR_GO = 2;
  localparam int NVM_CT_FTCH_EN = 1;
  localparam int NVM_CT_FTCH_GO = 0;

  // ***********************************************************
  // Geometry and timing
  // ***********************************************************
  localparam int  NVM_DEPTH         = 512;
  localparam int  NVM_AW            = 9;
  localparam int  NVM_PAGE_BYTES    = 16;
  localparam real NVM_CLK_PERIOD_NS = 5.0;
  localparam real NVM_ERASE_SHORT_MS = 3.2;
  localparam real NVM_ERASE_LONG_MS  = 3.7;
  localparam real NVM_WRITE_SHORT_MS = 2.2;
  localparam real NVM_WRITE_LONG_MS  = 3.0;
  localparam int  NVM_ERASE_SHORT_CYC = int'(NVM_ERASE_SHORT_MS * 1.0e6 / NVM_CLK_PERIOD_NS);
  localparam int  NVM_ERASE_LONG_CYC  = int'(NVM_ERASE_LONG_MS * 1.0e6 / NVM_CLK_PERIOD_NS);
  localparam int  NVM_WRITE_SHORT_CYC = int'(NVM_WRITE_SHORT_MS * 1.0e6 / NVM_CLK_PERIOD_NS);
  localparam int  NVM_WRITE_LONG_CYC  = int'(NVM_WRITE_LONG_MS * 1.0e6 / NVM_CLK_PERIOD_NS);
  localparam int  NVM_ARM_CYC         = 4;
  localparam int  NVM_TW              = 20;

  typedef enum logic [2:0] {
    NVM_ST_IDLE, NVM_ST_READ, NVM_ST_READ_DATA, NVM_ST_TIMER, NVM_ST_COMMIT
  } nvm_state_t;

endpackage : nvm_pkg

//--- src/nvm_mem_if.sv
// Carrier between the controller and its storage array
`timescale 1ns/1ps
interface nvm_mem_if #(parameter int AW = 9);
  logic          re;
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport ctrl (output re, output we, output addr, output wdata, input rdata);
  modport mem  (input re, input we, input addr, input wdata, output rdata);
endinterface : nvm_mem_if

//--- src/nvm_mem.sv
// Byte-wide storage array with registered read data
`timescale 1ns/1ps
module nvm_mem #(
  parameter int DEPTH = 512
) (
  input wire logic clk,
  nvm_mem_if.mem   bus
);

  logic [7:0] cell_ff [DEPTH];
  logic [7:0] rdata_ff;

  assign bus.rdata = rdata_ff;

  // Array has no reset, as on silicon; read word is valid one edge after re
  always_ff @(posedge clk) begin
    if (bus.we) begin
      cell_ff[bus.addr] <= bus.wdata;
    end
    if (bus.re) begin
      rdata_ff <= cell_ff[bus.addr];
    end
  end

endmodule : nvm_mem

//--- src/nvm_ctrl.sv
// Access controller for the 512-byte data storage, reached through sector 1
//
// Function
// - Storage is 512 bytes, address is high bit 8 over eight low bits.
// - Timing select picks erase 3.2/3.7 ms and write 2.2/3.0 ms.
// - Wipe enable gates erase; hardware clears it when erase ends.
// - Wipe start launches erase only if enable already high; self-clears.
// - Mode bit selects byte or 16-byte page operation.
// - Store enable gates write; hardware clears it when write ends.
// - Store start launches write only if enable already high; self-clears.
// - Fetch enable gates read; clearing it blocks reads.
// - Fetch start launches read only with enable high; self-clears.
// - High address register keeps only bit 0; bits 7..1 read zero.
// - Fetched byte sits in data register until next read or write.
// - Page mode bumps low nibble, saturating at 0FH, page bits kept.
// - Wipe or store enable then start must come back to back, else nothing starts; fetch needs no arming.
// - Page erase zeroes only the page bytes tagged by page-mode data writes.
`timescale 1ns/1ps
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int unsigned ERASE_SHORT = NVM_ERASE_SHORT_CYC,
  parameter int unsigned ERASE_LONG  = NVM_ERASE_LONG_CYC,
  parameter int unsigned WRITE_SHORT = NVM_WRITE_SHORT_CYC,
  parameter int unsigned WRITE_LONG  = NVM_WRITE_LONG_CYC,
  parameter int unsigned ARM_WINDOW  = NVM_ARM_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       reg_sel,
  input  wire logic       reg_we,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            op_done
);

  // ***********************************************************
  // State
  // ***********************************************************
  nvm_state_t        state_ff,    nxt_state;
  logic [7:0]        ctrl_ff,     nxt_ctrl;
  logic [7:0]        addr_lo_ff,  nxt_addr_lo;
  logic              addr_hi_ff,  nxt_addr_hi;
  logic [7:0]        data_ff,     nxt_data;
  logic [7:0]        rdata_ff,    nxt_rdata;
  logic [7:0]        pbuf_ff [NVM_PAGE_BYTES];
  logic [7:0]        nxt_pbuf [NVM_PAGE_BYTES];
  logic [15:0]       tag_ff,      nxt_tag;
  logic [NVM_TW-1:0] timer_ff,    nxt_timer;
  logic [3:0]        idx_ff,      nxt_idx;
  logic [7:0]        arm_cnt_ff,  nxt_arm_cnt;
  logic              arm_wipe_ff, nxt_arm_wipe;
  logic              arm_stor_ff, nxt_arm_stor;
  logic              erase_ff,    nxt_erase;
  logic              done_ff,     nxt_done;
  logic              wr;
  logic              page;
  logic              last;
  logic [NVM_TW-1:0] dur_erase;
  logic [NVM_TW-1:0] dur_write;

  nvm_mem_if #(.AW(NVM_AW)) mem_bus ();

  nvm_mem #(.DEPTH(NVM_DEPTH)) u_mem (
    .clk (clk),
    .bus (mem_bus.mem)
  );

  assign reg_rdata = rdata_ff;
  assign op_done   = done_ff;

  // Low nibble walks within the page and sticks at the top
  function automatic logic [7:0] nvm_bump(input logic [7:0] a);
    nvm_bump = (a[3:0] == 4'hF) ? a : {a[7:4], a[3:0] + 4'h1};
  endfunction : nvm_bump

  function automatic logic [7:0] nvm_read_mux(input logic [7:0] ofs, input logic [7:0] ct,
                                              input logic [7:0] lo, input logic hi,
                                              input logic [7:0] d);
    case (ofs)
      NVM_CTRL_OFS:    nvm_read_mux = ct;
      NVM_ADDR_LO_OFS: nvm_read_mux = lo;
      NVM_ADDR_HI_OFS: nvm_read_mux = {7'h00, hi};
      NVM_DATA_OFS:    nvm_read_mux = d;
      default:         nvm_read_mux = 8'h00;
    endcase
  endfunction : nvm_read_mux

  assign dur_erase = ctrl_ff[NVM_CT_TSEL] ? NVM_TW'(ERASE_LONG - 1)
                                          : NVM_TW'(ERASE_SHORT - 1);
  assign dur_write = ctrl_ff[NVM_CT_TSEL] ? NVM_TW'(WRITE_LONG - 1)
                                          : NVM_TW'(WRITE_SHORT - 1);
  assign wr   = reg_sel & reg_we;
  assign page = ctrl_ff[NVM_CT_PAGE];
  assign last = !page || (idx_ff == 4'hF);

  // ***********************************************************
  // Next-state logic
  // ***********************************************************
  always_comb begin
    nxt_state    = state_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_addr_lo  = addr_lo_ff;
    nxt_addr_hi  = addr_hi_ff;
    nxt_data     = data_ff;
    nxt_rdata    = rdata_ff;
    nxt_pbuf     = pbuf_ff;
    nxt_tag      = tag_ff;
    nxt_timer    = timer_ff;
    nxt_idx      = idx_ff;
    nxt_arm_cnt  = (arm_cnt_ff != 8'h00) ? arm_cnt_ff - 8'h01 : 8'h00;
    nxt_arm_wipe = arm_wipe_ff;
    nxt_arm_stor = arm_stor_ff;
    nxt_erase    = erase_ff;
    nxt_done     = 1'b0;
    mem_bus.re    = 1'b0;
    mem_bus.we    = 1'b0;
    mem_bus.addr  = {addr_hi_ff, addr_lo_ff};
    mem_bus.wdata = data_ff;

    if (reg_sel && !reg_we) begin
      nxt_rdata = nvm_read_mux(reg_addr, ctrl_ff, addr_lo_ff, addr_hi_ff, data_ff);
    end

    if (wr) begin
      // Any other register write between enable and start spoils the arming; reads do not
      nxt_arm_cnt  = 8'h00;
      nxt_arm_wipe = 1'b0;
      nxt_arm_stor = 1'b0;
      case (reg_addr)
        NVM_CTRL_OFS: begin
          nxt_ctrl[NVM_CT_TSEL]    = reg_wdata[NVM_CT_TSEL];
          nxt_ctrl[NVM_CT_WIPE_EN] = reg_wdata[NVM_CT_WIPE_EN];
          nxt_ctrl[NVM_CT_PAGE]    = reg_wdata[NVM_CT_PAGE];
          nxt_ctrl[NVM_CT_STOR_EN] = reg_wdata[NVM_CT_STOR_EN];
          nxt_ctrl[NVM_CT_FTCH_EN] = reg_wdata[NVM_CT_FTCH_EN];
          if (reg_wdata[NVM_CT_WIPE_EN] && !ctrl_ff[NVM_CT_WIPE_EN]) begin
            nxt_arm_wipe = 1'b1;
            nxt_arm_cnt  = 8'(ARM_WINDOW);
          end
          if (reg_wdata[NVM_CT_STOR_EN] && !ctrl_ff[NVM_CT_STOR_EN]) begin
            nxt_arm_stor = 1'b1;
            nxt_arm_cnt  = 8'(ARM_WINDOW);
          end
          if (ctrl_ff[NVM_CT_WIPE_EN] && !reg_wdata[NVM_CT_WIPE_EN]) begin
            nxt_tag = 16'h0000;
            for (int i = 0; i < NVM_PAGE_BYTES; i++) begin
              nxt_pbuf[i] = 8'h00;
            end
          end
          if (state_ff == NVM_ST_IDLE) begin
            // Write start outranks the others if software breaks the one-at-a-time rule
            if (reg_wdata[NVM_CT_STOR_GO] && ctrl_ff[NVM_CT_STOR_EN]
                && arm_stor_ff && arm_cnt_ff != 8'h00) begin
              nxt_ctrl[NVM_CT_STOR_GO] = 1'b1;
              nxt_erase = 1'b0;
              nxt_timer = dur_write;
              nxt_state = NVM_ST_TIMER;
            end else if (reg_wdata[NVM_CT_WIPE_GO] && ctrl_ff[NVM_CT_WIPE_EN]
                         && arm_wipe_ff && arm_cnt_ff != 8'h00) begin
              nxt_ctrl[NVM_CT_WIPE_GO] = 1'b1;
              nxt_erase = 1'b1;
              nxt_timer = dur_erase;
              nxt_state = NVM_ST_TIMER;
            end else if (reg_wdata[NVM_CT_FTCH_GO] && ctrl_ff[NVM_CT_FTCH_EN]) begin
              nxt_ctrl[NVM_CT_FTCH_GO] = 1'b1;
              nxt_state = NVM_ST_READ;
            end
          end
        end
        NVM_ADDR_LO_OFS: nxt_addr_lo = reg_wdata;
        NVM_ADDR_HI_OFS: nxt_addr_hi = reg_wdata[0];
        NVM_DATA_OFS: begin
          nxt_data = reg_wdata;
          if (page) begin
            // Data writes in page mode fill and tag the page buffer
            nxt_pbuf[addr_lo_ff[3:0]] = reg_wdata;
            nxt_tag[addr_lo_ff[3:0]]  = 1'b1;
            nxt_addr_lo = nvm_bump(addr_lo_ff);
          end
        end
        default: ;
      endcase
    end

    case (state_ff)
      NVM_ST_READ: begin
        mem_bus.re = 1'b1;
        nxt_state  = NVM_ST_READ_DATA;
      end
      NVM_ST_READ_DATA: begin
        nxt_data = mem_bus.rdata;
        nxt_ctrl[NVM_CT_FTCH_GO] = 1'b0;
        if (page) begin
          nxt_addr_lo = nvm_bump(addr_lo_ff);
        end
        nxt_done  = 1'b1;
        nxt_state = NVM_ST_IDLE;
      end
      NVM_ST_TIMER: begin
        if (timer_ff == '0) begin
          nxt_idx   = 4'h0;
          nxt_state = NVM_ST_COMMIT;
        end else begin
          nxt_timer = timer_ff - 1'b1;
        end
      end
      NVM_ST_COMMIT: begin
        // Byte write erases implicitly by overwriting; erase stores zero
        mem_bus.addr  = page ? {addr_hi_ff, addr_lo_ff[7:4], idx_ff} : {addr_hi_ff, addr_lo_ff};
        mem_bus.we    = page ? tag_ff[idx_ff] : 1'b1;
        mem_bus.wdata = erase_ff ? 8'h00 : (page ? pbuf_ff[idx_ff] : data_ff);
        nxt_idx = idx_ff + 4'h1;
        if (last) begin
          nxt_tag  = 16'h0000;
          nxt_done = 1'b1;
          nxt_state = NVM_ST_IDLE;
          if (erase_ff) begin
            nxt_ctrl[NVM_CT_WIPE_GO] = 1'b0;
            nxt_ctrl[NVM_CT_WIPE_EN] = 1'b0;
            for (int i = 0; i < NVM_PAGE_BYTES; i++) begin
              nxt_pbuf[i] = 8'h00;
            end
          end else begin
            nxt_ctrl[NVM_CT_STOR_GO] = 1'b0;
            nxt_ctrl[NVM_CT_STOR_EN] = 1'b0;
          end
        end
      end
      default: ;
    endcase
  end

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= NVM_ST_IDLE;
      ctrl_ff     <= NVM_REG_RESET;
      addr_lo_ff  <= NVM_REG_RESET;
      addr_hi_ff  <= 1'b0;
      data_ff     <= NVM_REG_RESET;
      rdata_ff    <= NVM_REG_RESET;
      tag_ff      <= 16'h0000;
      timer_ff    <= '0;
      idx_ff      <= 4'h0;
      arm_cnt_ff  <= 8'h00;
      arm_wipe_ff <= 1'b0;
      arm_stor_ff <= 1'b0;
      erase_ff    <= 1'b0;
      done_ff     <= 1'b0;
      for (int i = 0; i < NVM_PAGE_BYTES; i++) begin
        pbuf_ff[i] <= 8'h00;
      end
    end else begin
      state_ff    <= nxt_state;
      ctrl_ff     <= nxt_ctrl;
      addr_lo_ff  <= nxt_addr_lo;
      addr_hi_ff  <= nxt_addr_hi;
      data_ff     <= nxt_data;
      rdata_ff    <= nxt_rdata;
      tag_ff      <= nxt_tag;
      timer_ff    <= nxt_timer;
      idx_ff      <= nxt_idx;
      arm_cnt_ff  <= nxt_arm_cnt;
      arm_wipe_ff <= nxt_arm_wipe;
      arm_stor_ff <= nxt_arm_stor;
      erase_ff    <= nxt_erase;
      done_ff     <= nxt_done;
      pbuf_ff     <= nxt_pbuf;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  sequence s_fetch;
    state_ff == NVM_ST_READ ##1 state_ff == NVM_ST_READ_DATA;
  endsequence

  property p_hi_reads_zero;
    @(posedge clk) disable iff (!resetn)
    reg_sel && !reg_we && reg_addr == NVM_ADDR_HI_OFS |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_hi_reads_zero: assert property (p_hi_reads_zero)
    else $error("high address bits not zero");

  property p_fetch_blocked;
    @(posedge clk) disable iff (!resetn)
    wr && reg_addr == NVM_CTRL_OFS && reg_wdata[NVM_CT_FTCH_GO] && !ctrl_ff[NVM_CT_FTCH_EN]
      && state_ff == NVM_ST_IDLE |=> state_ff == NVM_ST_IDLE;
  endproperty
  a_fetch_blocked: assert property (p_fetch_blocked)
    else $error("read ran without enable");

  property p_wipe_blocked;
    @(posedge clk) disable iff (!resetn)
    wr && reg_addr == NVM_CTRL_OFS && !ctrl_ff[NVM_CT_WIPE_EN] && !ctrl_ff[NVM_CT_WIPE_GO]
      |=> !ctrl_ff[NVM_CT_WIPE_GO];
  endproperty
  a_wipe_blocked: assert property (p_wipe_blocked)
    else $error("erase ran without enable");

  property p_unarmed_store;
    @(posedge clk) disable iff (!resetn)
    wr && reg_addr == NVM_CTRL_OFS && arm_cnt_ff == 8'h00 && !ctrl_ff[NVM_CT_STOR_GO]
      |=> !ctrl_ff[NVM_CT_STOR_GO];
  endproperty
  a_unarmed_store: assert property (p_unarmed_store)
    else $error("write started unarmed");

  property p_timer_load;
    @(posedge clk) disable iff (!resetn)
    state_ff == NVM_ST_IDLE ##1 state_ff == NVM_ST_TIMER
      |-> (erase_ff ? timer_ff == $past(dur_erase) : timer_ff == $past(dur_write));
  endproperty
  a_timer_load: assert property (p_timer_load)
    else $error("cycle time wrong");

  property p_erase_end;
    @(posedge clk) disable iff (!resetn)
    state_ff == NVM_ST_COMMIT && last && erase_ff
      |=> !ctrl_ff[NVM_CT_WIPE_EN] && !ctrl_ff[NVM_CT_WIPE_GO] && done_ff;
  endproperty
  a_erase_end: assert property (p_erase_end)
    else $error("erase bits not cleared");

  property p_store_end;
    @(posedge clk) disable iff (!resetn)
    state_ff == NVM_ST_COMMIT && last && !erase_ff
      |=> !ctrl_ff[NVM_CT_STOR_EN] && !ctrl_ff[NVM_CT_STOR_GO] && done_ff;
  endproperty
  a_store_end: assert property (p_store_end)
    else $error("write bits not cleared");

  property p_fetch_result;
    @(posedge clk) disable iff (!resetn)
    s_fetch |=> !ctrl_ff[NVM_CT_FTCH_GO] && data_ff == $past(mem_bus.rdata);
  endproperty
  a_fetch_result: assert property (p_fetch_result)
    else $error("fetched byte not presented");

  property p_page_saturate;
    @(posedge clk) disable iff (!resetn)
    state_ff == NVM_ST_READ_DATA && page && !wr |=>
      addr_lo_ff[7:4] == $past(addr_lo_ff[7:4])
      && addr_lo_ff[3:0] == (($past(addr_lo_ff[3:0]) == 4'hF) ? 4'hF
                                                              : $past(addr_lo_ff[3:0]) + 4'h1);
  endproperty
  a_page_saturate: assert property (p_page_saturate)
    else $error("page address walk wrong");

  property p_erase_zero;
    @(posedge clk) disable iff (!resetn)
    mem_bus.we && erase_ff |-> mem_bus.wdata == 8'h00 && state_ff == NVM_ST_COMMIT;
  endproperty
  a_erase_zero: assert property (p_erase_zero)
    else $error("erase stored nonzero");

endmodule : nvm_ctrl

//--- test/nvm_cpu_model.sv
// Software-side model that reaches the storage registers by indirect access
`timescale 1ns/1ps
module nvm_cpu_model
  import nvm_pkg::*;
(
  input  wire logic       clk,
  output logic            reg_sel,
  output logic            reg_we,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       op_done
);
  // ***********************************************************
  // Access tasks
  // ***********************************************************
  initial begin
    reg_sel   = 1'b0;
    reg_we    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse so a stale value never passes
  task automatic drop();
    reg_sel   = 1'b0;
    reg_we    = ~reg_we;
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : drop

  // Offset is the pointer low byte, the high byte being sector 1
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_sel   = 1'b1;
    reg_we    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    drop();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_sel  = 1'b1;
    reg_we   = 1'b0;
    reg_addr = a;
    @(negedge clk);
    drop();
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // Enable alone, start on the next access; slow clock has no pin and is taken as settled
  task automatic start(input logic [7:0] en, input logic [7:0] go);
    wr(NVM_CTRL_OFS, en);
    wr(NVM_CTRL_OFS, en | go);
  endtask : start

  // Nothing else is touched until the cycle reports its end or 400 cycles pass
  task automatic wait_done(output int n);
    n = 0;
    while (op_done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_done

  task automatic quiet(input int c, output logic hit);
    hit = 1'b0;
    repeat (c) begin
      @(negedge clk);
      if (op_done === 1'b1) hit = 1'b1;
    end
  endtask : quiet
endmodule : nvm_cpu_model

//--- test/nvm_ctrl_tb.sv
// Self-checking bench for the storage access controller
`timescale 1ns/1ps
module nvm_ctrl_tb
  import nvm_pkg::*;
;
  // Short cycle counts keep the run small; only their differences are checked
  localparam int         W_S = 10;
  localparam int         W_L = 15;
  localparam int         E_S = 20;
  localparam int         E_L = 30;
  localparam logic [7:0] CT  = NVM_CTRL_OFS;
  localparam logic [7:0] LO  = NVM_ADDR_LO_OFS;
  localparam logic [7:0] HI  = NVM_ADDR_HI_OFS;
  localparam logic [7:0] DT  = NVM_DATA_OFS;

  logic       clk = 1'b0;
  logic       resetn;
  logic       reg_sel;
  logic       reg_we;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       op_done;
  logic       hit;
  logic [7:0] ts;
  int         fail_count;
  int         check_count;
  int         n[2];

  nvm_ctrl #(.ERASE_SHORT(E_S), .ERASE_LONG(E_L), .WRITE_SHORT(W_S),
             .WRITE_LONG(W_L)) DUT (
    .clk       (clk),
    .resetn    (resetn),
    .reg_sel   (reg_sel),
    .reg_we    (reg_we),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .op_done   (op_done)
  );

  nvm_cpu_model cpu (
    .clk       (clk),
    .reg_sel   (reg_sel),
    .reg_we    (reg_we),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .op_done   (op_done)
  );

  always #2.5 clk = ~clk;

  // ***********************************************************
  // Helpers
  // ***********************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    cpu.rd(a, v);
    check(what, v, exp);
  endtask : rdc

  task automatic done(input int i);
    cpu.wait_done(n[i]);
    check("op_done", 8'(n[i] < 400), 8'h01);
  endtask : done

  // A start that must not launch anything
  task automatic refused(input logic [7:0] c, input logic [7:0] exp, input string what);
    cpu.wr(CT, c);
    cpu.quiet(40, hit);
    check(what, {7'h00, hit}, 8'h00);
    rdc(CT, exp, what);
  endtask : refused

  task automatic page_fetch(input logic [7:0] e0, input logic [7:0] e1);
    cpu.wr(LO, 8'h2E);
    cpu.wr(CT, 8'h12);
    for (int k = 0; k < 2; k++) begin
      cpu.wr(CT, 8'h13);
      done(0);
      rdc(DT, k ? e1 : e0, "page fetch");
      rdc(LO, 8'h2F, "fetch nibble");
    end
  endtask : page_fetch

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // ***********************************************************
  // Tests
  // ***********************************************************
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    resetn      = 1'b0;
    fail_count  = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    rdc(CT, NVM_REG_RESET, "ctrl reset");
    rdc(LO, NVM_REG_RESET, "addr low reset");
    rdc(HI, NVM_REG_RESET, "addr high reset");
    rdc(DT, NVM_REG_RESET, "data reset");
    cpu.wr(8'h44, 8'h5A);
    rdc(8'h44, 8'h00, "unmapped");
    cpu.wr(HI, 8'hFF);
    rdc(HI, 8'h01, "addr high");
    cpu.wr(LO, 8'hA5);
    rdc(LO, 8'hA5, "addr low");
    $display("test registers done");
    refused(8'h01, 8'h00, "fetch go alone");
    refused(8'h20, 8'h00, "wipe go alone");
    refused(8'h04, 8'h00, "store go alone");
    cpu.wr(CT, 8'h08);
    cpu.wr(LO, 8'h23);
    refused(8'h0C, 8'h08, "store go late");
    cpu.wr(CT, 8'h40);
    cpu.quiet(8, hit);
    refused(8'h60, 8'h40, "wipe go late");
    cpu.wr(CT, 8'h00);
    $display("test refusals done");
    for (int i = 0; i < 2; i++) begin
      ts = i ? 8'h80 : 8'h00;
      cpu.wr(HI, i ? 8'h00 : 8'h01);
      cpu.wr(LO, 8'h23);
      cpu.wr(DT, i ? 8'hC3 : 8'h5A);
      cpu.start(ts | 8'h08, 8'h04);
      rdc(CT, ts | 8'h0C, "store busy");
      done(i);
      rdc(CT, ts, "store end");
    end
    check("write span", 8'(n[1] - n[0]), 8'(W_L - W_S));
    for (int i = 0; i < 2; i++) begin
      cpu.wr(HI, i ? 8'h00 : 8'h01);
      cpu.wr(LO, 8'h23);
      cpu.start(8'h02, 8'h01);
      done(i);
      rdc(CT, 8'h02, "fetch end");
      rdc(DT, i ? 8'hC3 : 8'h5A, "fetch byte");
      rdc(LO, 8'h23, "byte addr kept");
    end
    $display("test byte cycles done");
    cpu.wr(CT, 8'h10);
    cpu.wr(HI, 8'h01);
    cpu.wr(LO, 8'h2E);
    cpu.wr(DT, 8'h11);
    cpu.wr(DT, 8'h22);
    cpu.wr(DT, 8'h33);
    rdc(LO, 8'h2F, "fill nibble");
    rdc(HI, 8'h01, "fill page");
    cpu.start(8'h18, 8'h04);
    done(0);
    rdc(CT, 8'h10, "page store end");
    page_fetch(8'h11, 8'h33);
    $display("test page store done");
    for (int i = 0; i < 2; i++) begin
      ts = i ? 8'h80 : 8'h00;
      cpu.wr(CT, ts | 8'h10);
      cpu.wr(LO, 8'h2E);
      cpu.wr(DT, 8'hFF);
      cpu.wr(DT, 8'hFF);
      cpu.start(ts | 8'h50, 8'h20);
      done(i);
      rdc(CT, ts | 8'h10, "wipe end");
    end
    check("erase span", 8'(n[1] - n[0]), 8'(E_L - E_S));
    page_fetch(8'h00, 8'h00);
    $display("test page wipe done");
    close_out();
  end
endmodule : nvm_ctrl_tb
